// ===== core/adc_ctl.sv
/*
 * Register-side control of a 16-channel 16-bit converter on an IndustryPack
 * style register port: result, status, start trigger and interrupt vector.
 * Assumes the bus signals come from logic on clk, one strobe per access, and
 * that the converter sample is stable on adc_sample when the conversion count runs out.
 */
// Behaviour
// - Bipolar variants present the result as two's complement.
// - Unipolar variants present the result as straight binary.
// - Result at offset 0x02 is valid only while busy reads zero.
// - Status bit 1 is busy; in auto mode covers settling and conversion.
// - Status bit 0 is settling busy; upper status bits are undefined.
// - In normal mode a write to offset 0x07 while idle starts a conversion.
// - Start writes while busy are ignored, never queued.
// - Two interrupt sources, settling done and data ready, share one vector.
// - An acknowledge cycle clears the pending interrupt.
// - Vector bits 7:1 are software read/write, reset to zero.
// - Acknowledge bit 0 is one for settling done, zero for data ready.
// - Ordinary reads of the vector return zero in bit 0.
// - Settling done request fires on settle busy falling, normal mode only.
// - Data ready request fires on busy falling.
// - Setup bit 7 selects auto settling, bit 8 selects pipeline.
// - Pipeline mode loads the previous conversion result during the current one.
// - Auto mode setup write outside a running conversion starts conversion after the settling time.
`timescale 1ns/1ns
`include "adc_ctl_defines.svh"

module adc_ctl #(
  parameter bit BIPOLAR = 1'b1,
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter int CONVERT_CYCLES = `CONVERT_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Register port.
  input wire adc_ctl_pkg::bus_req_type bus_req,
  output adc_ctl_pkg::bus_rsp_type bus_rsp,
  // Converter sample, offset binary from the converter core.
  input wire logic [15:0] adc_sample,
  // Converter start pulse.
  output logic adc_start,
  // Setup fields for the analog front end.
  output logic [8:0] channel_setup,
  // Interrupt requests, active low.
  output logic intreq0_n,
  output logic intreq1_n
);

  localparam int TW = 12;

  typedef struct packed {
    adc_ctl_pkg::conv_state_type conv;
    logic [8:0] setup;
    logic [15:0] result;
    logic [15:0] last_sample;
    logic [6:0] vector;
    logic settle_prev;
    logic busy_prev;
    logic req_settle;
    logic req_data;
    logic start;
    adc_ctl_pkg::bus_rsp_type rsp;
  } ctl_state_type;

  ctl_state_type state_reg;
  ctl_state_type state_next;

  logic settle_load;
  logic conv_load;
  logic settle_run;
  logic conv_run;
  logic busy;

  // Converts the converter's offset binary into the variant's coding.
  function automatic logic [15:0] code_sample(input logic [15:0] raw);
    if (BIPOLAR) begin
      code_sample = {~raw[15], raw[14:0]};
    end else begin
      code_sample = raw;
    end
  endfunction : code_sample

  function automatic logic hit(input adc_ctl_pkg::bus_req_type r, input logic [5:0] ofs);
    hit = r.sel && (r.addr == ofs);
  endfunction : hit

  adc_ctl_timer #(.WIDTH(TW)) settle_timer (
    .clk(clk),
    .srst(srst),
    .load(settle_load),
    .count(TW'(SETTLE_CYCLES)),
    .running(settle_run)
  );

  adc_ctl_timer #(.WIDTH(TW)) conv_timer (
    .clk(clk),
    .srst(srst),
    .load(conv_load),
    .count(TW'(CONVERT_CYCLES)),
    .running(conv_run)
  );

  // Busy spans the settling wait in auto mode as well as the conversion.
  assign busy = (state_reg.conv != adc_ctl_pkg::CONV_IDLE);

  always_comb begin
    logic setup_wr;
    logic start_wr;
    logic conv_go;
    logic [15:0] coded;
    setup_wr = hit(bus_req, `OFS_CHANNEL_SETUP) && bus_req.wr;
    start_wr = hit(bus_req, `OFS_START_TRIGGER) && bus_req.wr;
    conv_go = 1'b0;
    coded = code_sample(adc_sample);
    state_next = state_reg;
    state_next.start = 1'b0;
    state_next.rsp.ack = 1'b0;
    state_next.settle_prev = settle_run;
    state_next.busy_prev = busy;
    settle_load = 1'b0;

    if (setup_wr) begin
      state_next.setup = bus_req.wdata[8:0];
      settle_load = 1'b1;
    end

    unique case (state_reg.conv)
      adc_ctl_pkg::CONV_IDLE: begin
        if (setup_wr && bus_req.wdata[`BIT_AUTO_SETTLE]) begin
          state_next.conv = adc_ctl_pkg::CONV_WAIT_SETTLE;
        end else if (start_wr && !state_reg.setup[`BIT_AUTO_SETTLE]) begin
          conv_go = 1'b1;
        end
      end
      adc_ctl_pkg::CONV_WAIT_SETTLE: begin
        if (!settle_run && !settle_load) begin
          conv_go = 1'b1;
        end
      end
      adc_ctl_pkg::CONV_RUN: begin
        // Start writes here fall through untouched.
        if (!conv_run && !state_reg.start) begin
          state_next.conv = adc_ctl_pkg::CONV_IDLE;
          state_next.last_sample = coded;
          if (!state_reg.setup[`BIT_PIPELINE]) begin
            state_next.result = coded;
          end
        end
      end
    endcase

    if (conv_go) begin
      state_next.conv = adc_ctl_pkg::CONV_RUN;
      state_next.start = 1'b1;
      if (state_reg.setup[`BIT_PIPELINE]) begin
        state_next.result = state_reg.last_sample;
      end
    end

    if (hit(bus_req, `OFS_IRQ_VECTOR) && bus_req.wr && !bus_req.iack) begin
      state_next.vector = bus_req.wdata[7:1];
    end

    // Acknowledge serves the settling request first when both pend.
    if (bus_req.sel && bus_req.iack) begin
      state_next.rsp.ack = 1'b1;
      if (state_reg.req_settle) begin
        state_next.rsp.rdata = {8'h00, state_reg.vector, 1'b1};
        state_next.req_settle = 1'b0;
      end else begin
        state_next.rsp.rdata = {8'h00, state_reg.vector, 1'b0};
        state_next.req_data = 1'b0;
      end
    end else if (bus_req.sel && (bus_req.rd || bus_req.wr)) begin
      state_next.rsp.ack = 1'b1;
      state_next.rsp.rdata = 16'h0000;
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          `OFS_CHANNEL_SETUP: state_next.rsp.rdata = {7'h00, state_reg.setup};
          `OFS_CONVERSION_RESULT: state_next.rsp.rdata = state_reg.result;
          `OFS_CONVERSION_FLAGS: state_next.rsp.rdata = {14'h0000, busy, settle_run};
          `OFS_IRQ_VECTOR: state_next.rsp.rdata = {8'h00, state_reg.vector, 1'b0};
          default: state_next.rsp.rdata = 16'h0000;
        endcase
      end
    end

    // Event sets win over a clearing acknowledge in the same cycle.
    if (state_reg.settle_prev && !settle_run && !state_reg.setup[`BIT_AUTO_SETTLE]) begin
      state_next.req_settle = 1'b1;
    end
    if (state_reg.busy_prev && !busy) begin
      state_next.req_data = 1'b1;
    end
  end

  assign conv_load = state_next.start;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= '0;
      state_reg.vector <= `VECTOR_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus_rsp = state_reg.rsp;
  assign adc_start = state_reg.start;
  assign channel_setup = state_reg.setup;
  assign intreq0_n = ~state_reg.req_data;
  assign intreq1_n = ~state_reg.req_settle;

endmodule : adc_ctl

// ===== core/adc_ctl_defines.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * converter control block. Assumes a 20 MHz system clock.
 */
`ifndef ADC_CTL_DEFINES_SVH
`define ADC_CTL_DEFINES_SVH

`define OFS_CHANNEL_SETUP 6'h00
`define OFS_CONVERSION_RESULT 6'h02
`define OFS_CONVERSION_FLAGS 6'h05
`define OFS_START_TRIGGER 6'h07
`define OFS_IRQ_VECTOR 6'h09
`define BIT_AUTO_SETTLE 7
`define BIT_PIPELINE 8
`define FLAG_SETTLE 0
`define FLAG_BUSY 1
`define VECTOR_RESET 7'h00
`define CLK_HZ 20000000
`define SETTLE_TIME_NS 10000
`define SETTLE_CYCLES ((`SETTLE_TIME_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define CONVERT_TIME_NS 8000
`define CONVERT_CYCLES ((`CONVERT_TIME_NS * (`CLK_HZ / 1000000) + 999) / 1000)

`endif

// ===== core/adc_ctl_pkg.sv
/*
 * Types of the converter control block. Constants live in the defines header.
 */
package adc_ctl_pkg;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic iack;
    logic [5:0] addr;
    logic [15:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } bus_rsp_type;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_WAIT_SETTLE,
    CONV_RUN
  } conv_state_type;

endpackage : adc_ctl_pkg

// ===== core/adc_ctl_timer.sv
/*
 * Down counter used for settling and conversion timing.
 * Assumes load has priority over counting and one clock domain.
 */
`timescale 1ns/1ns

module adc_ctl_timer #(
  parameter int WIDTH = 12
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Control.
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  // Status.
  output logic running
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } timer_state_type;

  timer_state_type state_reg;
  timer_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.cnt = count;
    end else if (state_reg.cnt != '0) begin
      state_next.cnt = state_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign running = (state_reg.cnt != '0);

endmodule : adc_ctl_timer

// ===== tb/adc_ctl_properties.sv
/* Port assertions for adc_ctl.
   Assumes it is bound into adc_ctl by tb_top, with one clock domain. */
`timescale 1ns/1ns
module adc_ctl_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Watched ports.
  input wire adc_ctl_pkg::bus_req_type bus_req,
  input wire adc_ctl_pkg::bus_rsp_type bus_rsp,
  input wire logic [15:0] adc_sample,
  input wire logic adc_start,
  input wire logic [8:0] channel_setup,
  input wire logic intreq0_n,
  input wire logic intreq1_n
);
  logic iack_c;
  logic rd_c;
  assign iack_c = bus_req.sel && bus_req.iack;
  assign rd_c = bus_req.sel && bus_req.rd && !bus_req.iack;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_vec_bit0; rd_c && bus_req.addr == 6'h09 |=> !bus_rsp.rdata[0]; endproperty
  a_vec_bit0: assert property (p_vec_bit0) else $error("vector bit 0 set");
  sequence s_setup(logic auto_bit);
    bus_req.sel && bus_req.wr && bus_req.addr == 6'h00 && bus_req.wdata[7] == auto_bit ##2 rd_c && bus_req.addr == 6'h05;
  endsequence
  property p_settle_flag; s_setup(1'b0) |=> bus_rsp.rdata[0]; endproperty
  a_settle_flag: assert property (p_settle_flag) else $error("settle flag low");
  property p_auto_busy; s_setup(1'b1) |=> bus_rsp.rdata[1]; endproperty
  a_auto_busy: assert property (p_auto_busy) else $error("busy low in settling");
  property p_req1_hold; !intreq1_n && !iack_c |=> !intreq1_n; endproperty
  a_req1_hold: assert property (p_req1_hold) else $error("intreq1 dropped");
  property p_req0_hold; !intreq0_n && !(iack_c && intreq1_n) |=> !intreq0_n; endproperty
  a_req0_hold: assert property (p_req0_hold) else $error("intreq0 dropped");
  property p_iack_settle; iack_c && !intreq1_n |=> bus_rsp.rdata[0] ##[0:1] intreq1_n; endproperty
  a_iack_settle: assert property (p_iack_settle) else $error("settle ack wrong");
  property p_iack_data; iack_c && intreq1_n && !intreq0_n |=> !bus_rsp.rdata[0] ##[0:1] intreq0_n; endproperty
  a_iack_data: assert property (p_iack_data) else $error("data ack wrong");
  property p_auto_quiet; channel_setup[7] && intreq1_n |=> intreq1_n; endproperty
  a_auto_quiet: assert property (p_auto_quiet) else $error("settle request in auto");
  property p_no_restart; adc_start |=> (!adc_start) [*3]; endproperty
  a_no_restart: assert property (p_no_restart) else $error("start repeated");
  c_settle_ack: cover property (iack_c && !intreq1_n);
  c_data_ack: cover property (iack_c && intreq1_n && !intreq0_n);
  c_auto_start: cover property (adc_start && channel_setup[7]);
endmodule : adc_ctl_properties

// ===== tb/adc_host_model.sv
/* Register-port host: one access per call, strobe one cycle as the port asks.
   Assumes clk is the block clock; signals change on falling edges. */
`timescale 1ns/1ns
module adc_host_model (
  // Clock.
  input wire logic clk,
  // Register port.
  output adc_ctl_pkg::bus_req_type bus_req,
  input wire adc_ctl_pkg::bus_rsp_type bus_rsp
);
  initial bus_req = '0;
  task automatic acc(input logic rd, input logic wr, input logic ia, input logic [5:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    @(negedge clk);
    bus_req <= '{1'b1, rd, wr, ia, a, d};
    @(negedge clk);
    // Idle address and data show inverted junk so stale values are not trusted.
    bus_req <= '{1'b0, 1'b0, 1'b0, 1'b0, ~a, ~d};
    @(posedge clk);
    r = bus_rsp.rdata;
  endtask : acc
endmodule : adc_host_model

// ===== tb/tb_top.sv
/* Self-checking bench for adc_ctl with a host model and bound checker.
   Assumes short settling and conversion counts of 5 and 4 cycles. */
`timescale 1ns/1ns
module tb_top;
  localparam logic [2:0] RD = 3'b100;
  localparam logic [2:0] WR = 3'b010;
  localparam logic [2:0] IA = 3'b001;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] adc_sample = 16'h0000;
  adc_ctl_pkg::bus_req_type bus_req;
  adc_ctl_pkg::bus_rsp_type bus_rsp;
  adc_ctl_pkg::bus_rsp_type uni_rsp;
  logic adc_start;
  logic [8:0] channel_setup;
  logic intreq0_n;
  logic intreq1_n;
  logic [31:0] q[$];
  logic [31:0] note;
  int n_fail = 0;
  int checked = 0;
  int starts = 0;
  always #25 clk = ~clk;
  adc_ctl #(.BIPOLAR(1'b1), .SETTLE_CYCLES(5), .CONVERT_CYCLES(4)) u_adc_ctl (
    .clk(clk),
    .srst(srst),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .adc_sample(adc_sample),
    .adc_start(adc_start),
    .channel_setup(channel_setup),
    .intreq0_n(intreq0_n),
    .intreq1_n(intreq1_n)
  );
  // A unipolar twin shares the bus and the sample, so only its read data needs watching.
  adc_ctl #(.BIPOLAR(1'b0), .SETTLE_CYCLES(5), .CONVERT_CYCLES(4)) u_adc_ctl_uni (
    .clk(clk),
    .srst(srst),
    .bus_req(bus_req),
    .bus_rsp(uni_rsp),
    .adc_sample(adc_sample),
    .adc_start(),
    .channel_setup(),
    .intreq0_n(),
    .intreq1_n()
  );
  adc_host_model u_adc_host_model (.clk(clk), .bus_req(bus_req), .bus_rsp(bus_rsp));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // Each access leaves a mask and expected value for the response monitor.
  task automatic acc(input logic [2:0] k, input logic [5:0] a, input logic [15:0] d, input logic [15:0] m,
                     input logic [15:0] e, output logic [15:0] r);
    q.push_back({m, e});
    u_adc_host_model.acc(k[2], k[1], k[0], a, d, r);
  endtask : acc
  task automatic poll(input int b, output logic [15:0] r);
    r = 16'hffff;
    for (int i = 0; i < 40 && r[b] !== 1'b0; i++) acc(RD, 6'h05, 16'h0000, 16'h0000, 16'h0000, r);
    chk("status", {15'h0, r[b]}, 16'h0000);
  endtask : poll
  task automatic irq(input logic w);
    for (int i = 0; i < 20 && (w ? intreq1_n : intreq0_n) !== 1'b0; i++) @(negedge clk);
    chk("intreq", {15'h0, w ? intreq1_n : intreq0_n}, 16'h0000);
  endtask : irq
  always @(posedge clk) begin
    if (bus_rsp.ack === 1'b1) begin
      // An acknowledge with no access outstanding is itself a fault.
      if (q.size() == 0) begin
        chk("ack", 16'h0001, 16'h0000);
      end else begin
        note = q.pop_front();
        if (note[31:16] != 16'h0000) begin
          chk("rdata", bus_rsp.rdata & note[31:16], note[15:0]);
        end
      end
    end
    if (adc_start === 1'b1) starts++;
  end
  initial begin
    logic [15:0] r;
    logic [15:0] s;
    logic [15:0] prev;
    logic [8:0] mode;
    r = 16'($urandom(32'ha58d13c8));
    prev = 16'h0000;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    acc(RD, 6'h09, 16'h0000, 16'h00ff, 16'h0000, r);
    acc(RD, 6'h05, 16'h0000, 16'h0003, 16'h0000, r);
    acc(WR, 6'h09, 16'h0061, 16'h0000, 16'h0000, r);
    acc(RD, 6'h09, 16'h0000, 16'h00ff, 16'h0060, r);
    acc(RD, 6'h3e, 16'h0000, 16'hffff, 16'h0000, r);
    for (int m = 0; m < 4; m++) begin
      s = 16'($urandom);
      @(negedge clk);
      adc_sample <= s;
      mode = {m[1], m[0], 7'h00};
      acc(WR, 6'h00, {7'h00, mode}, 16'h0000, 16'h0000, r);
      acc(RD, 6'h05, 16'h0000, m[0] ? 16'h0002 : 16'h0003, m[0] ? 16'h0002 : 16'h0001, r);
      if (!m[0]) begin
        poll(0, r);
        irq(1'b1);
        acc(IA, 6'h00, 16'h0000, 16'h00ff, 16'h0061, r);
      end
      acc(WR, 6'h07, s, 16'h0000, 16'h0000, r);
      acc(WR, 6'h07, ~s, 16'h0000, 16'h0000, r);
      poll(1, r);
      acc(RD, 6'h02, 16'h0000, 16'hffff, (m[1] ? prev : s) ^ 16'h8000, r);
      chk("result_uni", uni_rsp.rdata, m[1] ? prev : s);
      prev = s;
      irq(1'b0);
      chk("intreq1_n", {15'h0, intreq1_n}, 16'h0001);
      acc(IA, 6'h00, 16'h0000, 16'h00ff, 16'h0060, r);
      acc(RD, 6'h00, 16'h0000, 16'h01ff, {7'h00, mode}, r);
      chk("channel_setup", {7'h00, channel_setup}, {7'h00, mode});
      chk("starts", 16'(starts), 16'(m + 1));
    end
    // A reset with the block idle and both requests already acknowledged must drop the loaded vector and the setup copy and leave both requests off.
    @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    acc(RD, 6'h09, 16'h0000, 16'h00ff, 16'h0000, r);
    acc(RD, 6'h05, 16'h0000, 16'h0003, 16'h0000, r);
    @(negedge clk);
    chk("channel_setup", {7'h00, channel_setup}, 16'h0000);
    chk("intreq", {14'h0000, intreq1_n, intreq0_n}, 16'h0003);
    chk("queue", 16'(q.size()), 16'h0000);
    print_verdict();
  end
  initial begin
    #(50 * 20000);
    n_fail++;
    print_verdict();
  end
endmodule : tb_top
bind adc_ctl adc_ctl_properties u_adc_ctl_properties (
  .clk(clk),
  .srst(srst),
  .bus_req(bus_req),
  .bus_rsp(bus_rsp),
  .adc_sample(adc_sample),
  .adc_start(adc_start),
  .channel_setup(channel_setup),
  .intreq0_n(intreq0_n),
  .intreq1_n(intreq1_n)
);
